// *** shared/supervisor_defs.svh ***
// Offsets, field positions, key and fault codes and timing counts of the supervisor.
`ifndef SUPERVISOR_DEFS_SVH
`define SUPERVISOR_DEFS_SVH
`define CLK_MHZ 125
`define REG_STATUS 8'h10
`define REG_SPEED_LO 8'h00
`define REG_SPEED_HI 8'h01
`define REG_DEV_CTRL 8'h02
`define REG_NVM_CTRL 8'h03
`define REG_FAULT_CODE 8'h04
`define REG_DUTY 8'h05
`define REG_PARAM_FIRST 8'h20
`define REG_PARAM_LAST 8'h2B
`define ST_OT_BIT 7
`define ST_LP_BIT 6
`define ST_OC_BIT 5
`define ST_LOCK_BIT 4
`define DEV_SRC_BIT 7
`define DEV_INHIBIT_BIT 6
`define DEV_MODE_LSB 4
`define NVM_WRITE_BIT 0
`define NVM_KEY 8'hB6
`define FAULT_LOCK_CODE 8'h01
`define FAULT_OC_CODE 8'h02
`define NVM_WRITE_MS 24
`define NVM_WRITE_CYC (`NVM_WRITE_MS * 1000 * `CLK_MHZ)
`define LOCK_OFF_MS 5000
`define LOCK_OFF_CYC (`LOCK_OFF_MS * 1000 * `CLK_MHZ)
`define LP_QUAL_US 1000
`define LP_QUAL_CYC (`LP_QUAL_US * `CLK_MHZ)
`define NVM_WORDS 12
`endif

// *** shared/supervisor_pkg.sv ***
// Types used by the device end of the supervisor link.
`default_nettype none
package supervisor_pkg;
  typedef enum logic [1:0] {SRC_PWM, SRC_ANALOG, SRC_I2C, SRC_RSVD}
    speed_source_type;
  typedef enum logic {VARIANT_STANDBY, VARIANT_SLEEP} power_variant_type;
endpackage
`default_nettype wire

// *** shared/supervisor_if.sv ***
// Register link between the controller and the supervisor.
`default_nettype none
interface supervisor_if (input wire logic pclk, input wire logic presetn);
  logic req;
  logic we;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic ack;
  logic link_up;
  logic speed_pin_high;
  modport device (input req, input we, input addr, input wdata,
    input speed_pin_high, output rdata, output ack, output link_up);
  modport host (output req, output we, output addr, output wdata,
    output speed_pin_high, input rdata, input ack, input link_up);
endinterface
`default_nettype wire

// *** design/motor_drive_supervisor.sv ***
// Supervisory logic of the sensorless motor driver (device end).
// What this block does
// [R1] Undervoltage lockout with rising-threshold hysteresis
// [R2] Overcurrent tri-states drivers while present
// [R3] Overcurrent flag at status bit 5
// [R4] Locked rotor: stop, wait 5000 ms, retry
// [R5] Lock flag bit 4, cause in fault code
// [R6] Speed from pin PWM, pin analog, or register
// [R7] Peak duty from command, clamped by limiters
// [R8] Sectors 0 to 2: one phase grounded, two modulated; sector 3: none grounded, all three modulated
// [R9] Peak duty scales amplitude against supply
// [R10] Sleep stops drive, link off, volatile reset
// [R11] Standby keeps regulator, registers and link
// [R12] Inhibit blocks entry, does not wake
// [R13] Low-power flag at status bit 6
// [R14] Pin low qualifies entry, high exits
// [R15] Zero register speed enters; nonzero ends standby
// [R16] Ninety-six bits of parameter storage
// [R17] Host unlocks, writes params, key, start
// [R18] Write lasts 24 ms, start self-clears
// [R19] Host programs with motor stopped
// [R20] Host writes resistance and BEMF codes
// [R21] Over-temperature flag at status bit 7
// [R22] Storage copied to registers at wake
// [R23] Flags track conditions, ignore host writes
//
// The APB interface to the registers is this design's own decision.
`include "supervisor_defs.svh"
`default_nettype none
module motor_drive_supervisor #(
  parameter int unsigned NVM_CYC = `NVM_WRITE_CYC,
  parameter int unsigned LOCK_CYC = `LOCK_OFF_CYC,
  parameter int unsigned QUAL_CYC = `LP_QUAL_CYC,
  parameter supervisor_pkg::power_variant_type VARIANT =
    supervisor_pkg::VARIANT_STANDBY
) (
  // Register link
  supervisor_if.device bus,
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Analog comparator and sensor levels
  input wire logic supply_above_fall,
  input wire logic supply_above_rise,
  input wire logic fet_overcurrent,
  input wire logic rotor_locked,
  input wire logic over_temperature,
  input wire logic speed_analog_above_standby,
  input wire logic speed_analog_above_sleep,
  input wire logic [8:0] speed_pin_command,
  input wire logic [8:0] duty_limit,
  input wire logic [1:0] commutation_sector,
  // Drive and power outputs
  output logic [8:0] output_peak_duty,
  output logic [2:0] phase_pwm_enable,
  output logic [2:0] phase_low_enable,
  output logic regulator_enable,
  output logic drivers_hiz
);
  typedef enum logic [1:0] {RUN, LOCK_WAIT, LOW_POWER} mode_type;
  typedef struct packed {
    logic uvlo;
    mode_type mode;
    logic [31:0] timer;
    logic [31:0] qual;
    logic [8:0] speed_command_field;
    logic [7:0] device_control_reg;
    logic [7:0] nvm_control_reg;
    logic [7:0] fault_cause_code;
    logic [31:0] nvm_timer;
    logic [8:0] duty;
    logic [7:0] rdata;
    logic ack;
    logic [95:0] nvm;
    logic [95:0] params;
  } state_type;
  state_type s_reg, s_next;
  logic stop_drive, pin_low, pin_high_exit, lp_enter, lp_exit, in_lp;
  logic [8:0] cmd;
  logic [7:0] status;
  supervisor_pkg::speed_source_type src;

  function automatic logic is_param(input logic [7:0] a);
    return a >= `REG_PARAM_FIRST && a <= `REG_PARAM_LAST;
  endfunction

  always_comb begin
    src = supervisor_pkg::speed_source_type'(
      s_reg.device_control_reg[`DEV_MODE_LSB +: 2]);
    in_lp = s_reg.mode == LOW_POWER;
    status = 8'h00;
    status[`ST_OT_BIT] = over_temperature; // [R21] [R23]
    status[`ST_LP_BIT] = in_lp; // [R13] [R23]
    status[`ST_OC_BIT] = fet_overcurrent; // [R3] [R23]
    status[`ST_LOCK_BIT] = s_reg.mode == LOCK_WAIT || rotor_locked; // [R5]
    // Analog mode uses the standby comparator for entry, not the pin digital level.
    pin_low = (src == supervisor_pkg::SRC_ANALOG) ?
      !speed_analog_above_standby : !bus.speed_pin_high; // [R14]
    if (src == supervisor_pkg::SRC_ANALOG) begin
      pin_high_exit = (VARIANT == supervisor_pkg::VARIANT_SLEEP) ?
        speed_analog_above_sleep : speed_analog_above_standby; // [R14]
    end else begin
      pin_high_exit = bus.speed_pin_high;
    end
    if (src == supervisor_pkg::SRC_I2C) begin
      lp_enter = s_reg.speed_command_field == 9'h000; // [R15]
      lp_exit = (VARIANT == supervisor_pkg::VARIANT_SLEEP) ?
        bus.speed_pin_high : s_reg.speed_command_field != 9'h000; // [R15]
      cmd = s_reg.speed_command_field; // [R6]
    end else begin
      lp_enter = pin_low;
      lp_exit = pin_high_exit;
      cmd = speed_pin_command; // [R6]
    end
  end

  always_comb begin
    s_next = s_reg;
    s_next.ack = 1'b0;
    // Hysteresis: drop at the low threshold, release only at the high one.
    if (!supply_above_fall) s_next.uvlo = 1'b1; // [R1]
    else if (supply_above_rise) s_next.uvlo = 1'b0; // [R1]
    // Leaving lockout counts as power-up: reload the stored parameters.
    if (s_reg.uvlo && !s_next.uvlo) s_next.params = s_reg.nvm; // [R22]
    if (fet_overcurrent) s_next.fault_cause_code = `FAULT_OC_CODE; // [R5]
    unique case (s_reg.mode)
      RUN: begin
        if (rotor_locked) begin
          s_next.mode = LOCK_WAIT; // [R4]
          s_next.timer = 32'h0;
          s_next.fault_cause_code = `FAULT_LOCK_CODE; // [R5]
        end else if (lp_enter
            && !s_reg.device_control_reg[`DEV_INHIBIT_BIT]) begin
          s_next.qual = s_reg.qual + 32'h1;
          if (s_reg.qual >= QUAL_CYC - 1) begin
            s_next.mode = LOW_POWER; // [R12] [R14]
            s_next.qual = 32'h0;
          end
        end else begin
          s_next.qual = 32'h0;
        end
      end
      LOCK_WAIT: begin
        s_next.timer = s_reg.timer + 32'h1;
        if (s_reg.timer >= LOCK_CYC - 1) s_next.mode = RUN; // [R4]
      end
      LOW_POWER: begin
        // Inhibit is not consulted here, so setting it never wakes.
        if (lp_exit) begin
          s_next.qual = s_reg.qual + 32'h1;
          if (s_reg.qual >= QUAL_CYC - 1) begin
            s_next.mode = RUN; // [R14] [R15]
            s_next.qual = 32'h0;
            if (VARIANT == supervisor_pkg::VARIANT_SLEEP) begin
              s_next.params = s_reg.nvm; // [R22]
            end
          end
        end else begin
          s_next.qual = 32'h0;
        end
      end
      default: s_next.mode = RUN;
    endcase
    if (s_next.mode == LOW_POWER && s_reg.mode != LOW_POWER
        && VARIANT == supervisor_pkg::VARIANT_SLEEP) begin
      s_next.speed_command_field = 9'h000; // [R10]
      s_next.device_control_reg = 8'h00;
      s_next.nvm_control_reg = 8'h00;
      s_next.fault_cause_code = 8'h00;
    end
    if (s_reg.nvm_control_reg[`NVM_WRITE_BIT]) begin
      s_next.nvm_timer = s_reg.nvm_timer + 32'h1;
      if (s_reg.nvm_timer >= NVM_CYC - 1) begin
        s_next.nvm = s_reg.params; // [R16] [R18]
        s_next.nvm_control_reg[`NVM_WRITE_BIT] = 1'b0; // [R18]
        s_next.nvm_timer = 32'h0;
      end
    end
    s_next.duty = (cmd > duty_limit) ? duty_limit : cmd; // [R7]
    if (bus.req && bus.link_up && !s_reg.ack) begin
      s_next.ack = 1'b1;
      s_next.rdata = 8'h00;
      if (bus.we) begin
        unique case (bus.addr)
          `REG_SPEED_LO: s_next.speed_command_field[7:0] = bus.wdata;
          `REG_SPEED_HI: s_next.speed_command_field[8] = bus.wdata[0];
          `REG_DEV_CTRL: s_next.device_control_reg = bus.wdata;
          `REG_NVM_CTRL: begin
            // The start bit is honoured only with source and key set.
            if (s_reg.device_control_reg[`DEV_SRC_BIT]
                && s_reg.nvm_control_reg == `NVM_KEY) begin
              s_next.nvm_control_reg = bus.wdata & 8'h01; // [R17]
            end else begin
              s_next.nvm_control_reg = bus.wdata & 8'hFE; // [R17]
            end
          end
          default: if (is_param(bus.addr)) begin
            s_next.params[(bus.addr - `REG_PARAM_FIRST) * 8 +: 8] =
              bus.wdata; // [R20]
          end
        endcase
      end else begin
        unique case (bus.addr)
          `REG_STATUS: s_next.rdata = status; // [R23]
          `REG_SPEED_LO: s_next.rdata = s_reg.speed_command_field[7:0];
          `REG_SPEED_HI: s_next.rdata = {7'h00, s_reg.speed_command_field[8]};
          `REG_DEV_CTRL: s_next.rdata = s_reg.device_control_reg;
          `REG_NVM_CTRL: s_next.rdata = s_reg.nvm_control_reg;
          `REG_FAULT_CODE: s_next.rdata = s_reg.fault_cause_code;
          `REG_DUTY: s_next.rdata = s_reg.duty[8:1];
          default: if (is_param(bus.addr)) begin
            s_next.rdata =
              s_reg.params[(bus.addr - `REG_PARAM_FIRST) * 8 +: 8];
          end
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
      s_reg.uvlo <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // Drivers stop on any protection or low-power condition.
  assign stop_drive = s_reg.uvlo || fet_overcurrent || over_temperature
    || s_reg.mode != RUN; // [R1] [R2] [R4] [R10]
  assign drivers_hiz = stop_drive; // [R2]
  assign output_peak_duty = stop_drive ? 9'h000 : s_reg.duty; // [R9]
  // In sectors 0 to 2 one phase clamps low while the other two modulate; sector 3 clamps none and modulates all three.
  generate
    for (genvar p = 0; p < 3; p++) begin : g_phase
      assign phase_low_enable[p] = !stop_drive
        && commutation_sector == 2'(p); // [R8]
      assign phase_pwm_enable[p] = !stop_drive
        && commutation_sector != 2'(p); // [R8]
    end
  endgenerate
  assign regulator_enable = !(in_lp
    && VARIANT == supervisor_pkg::VARIANT_SLEEP); // [R10] [R11]
  assign bus.link_up = regulator_enable; // [R10] [R11]
  assign bus.ack = s_reg.ack;
  assign bus.rdata = s_reg.rdata;
endmodule
`default_nettype wire

// *** design/supervisor_controller.sv ***
// Controller end: APB slave that relays orders to the supervisor link.
`include "supervisor_defs.svh"
`default_nettype none
module supervisor_controller (
  // Link to the supervisor
  supervisor_if.host link,
  // APB slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Speed pin drive
  input wire logic speed_pin_level
);
  typedef struct packed {
    logic busy;
    logic done;
    logic err;
    logic [7:0] data;
  } state_type;
  state_type s_reg, s_next;
  logic access;

  // Each device register is one word at byte address offset times four.
  always_comb begin
    access = psel && penable;
    s_next = s_reg;
    s_next.done = 1'b0;
    if (access && !s_reg.busy && !s_reg.done) begin
      if (paddr[31:10] != 22'h0 || paddr[1:0] != 2'h0 || !link.link_up) begin
        s_next.done = 1'b1;
        s_next.err = 1'b1;
      end else begin
        s_next.busy = 1'b1; // [R17] [R20]
        s_next.err = 1'b0;
      end
    end else if (s_reg.busy && link.ack) begin
      s_next.busy = 1'b0;
      s_next.done = 1'b1;
      s_next.data = link.rdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) s_reg <= '0;
    else s_reg <= s_next;
  end

  assign link.req = s_reg.busy;
  assign link.we = pwrite;
  assign link.addr = paddr[9:2];
  assign link.wdata = pwdata[7:0];
  assign link.speed_pin_high = speed_pin_level; // [R6] [R15]
  assign pready = s_reg.done;
  assign pslverr = s_reg.done && s_reg.err;
  assign prdata = {24'h000000, s_reg.data};
endmodule
`default_nettype wire

// *** tb/supervisor_link_chk.sv ***
// Protocol checker for the register link between the two ends.
`default_nettype none
module supervisor_link_chk (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Link signals
  input wire logic req,
  input wire logic we,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic ack,
  input wire logic link_up,
  input wire logic speed_pin_high
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ack_one_cycle: assert property (ack |=> !ack)
    else $error("ack stood longer than one cycle");
  a_ack_needs_req: assert property (ack |-> $past(req))
    else $error("ack without a request");
  a_req_answered: assert property (req && !ack |=> ack)
    else $error("request not answered next cycle");
  a_req_held: assert property (req && !ack |=> req)
    else $error("request dropped before ack");
  a_req_steady: assert property (req && !ack
    |=> $stable({we, addr, wdata}))
    else $error("request changed before ack");
  a_req_released: assert property (ack |=> !req)
    else $error("request kept after ack");
  a_link_kept_up: assert property (link_up)
    else $error("link went down in the standby variant");
  a_walk_timing: assert property ($rose(req)
    |-> !ack ##1 ack ##1 !ack)
    else $error("link walk timing wrong");
endmodule
`default_nettype wire

// *** tb/motor_drive_supervisor_tb.sv ***
// Testbench joining controller and supervisor over the link.
`default_nettype none
module motor_drive_supervisor_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, pready, pslverr, spd = 1'b1, er, reg_en, hiz;
  logic fall = 1'b1, rise = 1'b1, oc = 1'b0, lck = 1'b0, ot = 1'b0;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd, seed = 32'h5B;
  logic [8:0] pin_cmd = 9'h0, lim = 9'h1FF, duty;
  logic [2:0] pwm_en, low_en;
  logic [1:0] sector = 2'h0;
  logic [7:0] prm [12];
  logic [7:0] sv;
  int err_count = 0, checks_done = 0;
  always #4 pclk = ~pclk;
  supervisor_if i_supervisor_if (.pclk(pclk), .presetn(presetn));
  motor_drive_supervisor #(.NVM_CYC(20), .LOCK_CYC(10), .QUAL_CYC(4))
    i_motor_drive_supervisor (.bus(i_supervisor_if), .pclk(pclk),
    .presetn(presetn), .supply_above_fall(fall), .supply_above_rise(rise),
    .fet_overcurrent(oc), .rotor_locked(lck), .over_temperature(ot),
    .speed_analog_above_standby(1'b1), .speed_analog_above_sleep(1'b1),
    .speed_pin_command(pin_cmd), .duty_limit(lim),
    .commutation_sector(sector), .output_peak_duty(duty),
    .phase_pwm_enable(pwm_en), .phase_low_enable(low_en),
    .regulator_enable(reg_en), .drivers_hiz(hiz));
  supervisor_controller i_supervisor_controller (.link(i_supervisor_if),
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .speed_pin_level(spd));
  supervisor_link_chk i_supervisor_link_chk (.pclk(pclk),
    .presetn(presetn), .req(i_supervisor_if.req), .we(i_supervisor_if.we),
    .addr(i_supervisor_if.addr), .wdata(i_supervisor_if.wdata),
    .rdata(i_supervisor_if.rdata), .ack(i_supervisor_if.ack),
    .link_up(i_supervisor_if.link_up),
    .speed_pin_high(i_supervisor_if.speed_pin_high));
  function automatic logic [7:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction
  // Expected upper nibble of the status register.
  function automatic logic [3:0] st(int t, int l, int o, int k);
    return {t[0], l[0], o[0], k[0]};
  endfunction
  // Expected peak duty: the command, cut down to the limiter's ceiling.
  function automatic logic [8:0] clamp(logic [8:0] c, logic [8:0] l);
    return (c > l) ? l : c;
  endfunction
  task automatic end_of_test();
    $display("errors %0d checks %0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", n, e, g);
      err_count++;
    end
  endtask
  // Word index N of the device sits at byte 4N.
  task automatic apb(logic w, logic [7:0] n, logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {22'h0, n, 2'h0};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // No cycle count is assumed; only the watchdog ends a hung wait.
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rst(logic [3:0] e);
    apb(1'b0, 8'h10, 32'h0);
    chk("status", {28'h0, e}, {28'h0, rd[7:4]});
  endtask
  initial begin
    #100000;
    err_count++;
    end_of_test();
  end
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b1, 8'h10, 32'hFF);
    rst(st(0, 0, 0, 0));
    oc <= 1'b1;
    repeat (2) @(posedge pclk);
    chk("hiz", 32'h1, {31'h0, hiz});
    rst(st(0, 0, 1, 0));
    apb(1'b0, 8'h04, 32'h0);
    chk("fault", 32'h2, {24'h0, rd[7:0]});
    oc <= 1'b0;
    rst(st(0, 0, 0, 0));
    lck <= 1'b1;
    rst(st(0, 0, 0, 1));
    chk("pwm_en", 32'h0, {29'h0, pwm_en});
    apb(1'b0, 8'h04, 32'h0);
    chk("fault", 32'h1, {24'h0, rd[7:0]});
    lck <= 1'b0;
    repeat (12) @(posedge pclk);
    rst(st(0, 0, 0, 0));
    ot <= 1'b1;
    rst(st(1, 0, 0, 0));
    ot <= 1'b0;
    fall <= 1'b0;
    rise <= 1'b0;
    repeat (2) @(posedge pclk);
    fall <= 1'b1;
    repeat (2) @(posedge pclk);
    chk("hiz", 32'h1, {31'h0, hiz});
    rise <= 1'b1;
    spd <= 1'b0;
    repeat (8) @(posedge pclk);
    rst(st(0, 1, 0, 0));
    chk("pwm_en", 32'h0, {29'h0, pwm_en});
    chk("reg_en", 32'h1, {31'h0, reg_en});
    apb(1'b1, 8'h02, 32'h40);
    rst(st(0, 1, 0, 0));
    spd <= 1'b1;
    repeat (8) @(posedge pclk);
    rst(st(0, 0, 0, 0));
    spd <= 1'b0;
    repeat (8) @(posedge pclk);
    rst(st(0, 0, 0, 0));
    spd <= 1'b1;
    apb(1'b1, 8'h02, 32'h20);
    apb(1'b1, 8'h00, 32'h0);
    apb(1'b1, 8'h01, 32'h0);
    repeat (8) @(posedge pclk);
    rst(st(0, 1, 0, 0));
    sv = xs() | 8'h01;
    apb(1'b1, 8'h00, {24'h0, sv});
    repeat (8) @(posedge pclk);
    rst(st(0, 0, 0, 0));
    chk("duty", {24'h0, sv}, {23'h0, duty});
    apb(1'b1, 8'h02, 32'h80);
    // Pin command above the ceiling, so the limiter must cut it.
    pin_cmd <= {1'b1, xs()};
    lim <= {1'b0, xs()};
    sector <= 2'(xs() % 3);
    repeat (3) @(posedge pclk);
    chk("duty", {23'h0, clamp(pin_cmd, lim)}, {23'h0, duty});
    chk("low_en", {29'h0, 3'(1 << sector)}, {29'h0, low_en});
    chk("pwm_en", {29'h0, ~3'(1 << sector)}, {29'h0, pwm_en});
    lim <= 9'h000;
    for (int k = 0; k < 12; k++) begin
      prm[k] = xs() & 8'h7F;
      apb(1'b1, 8'h20 + 8'(k), {24'h0, prm[k]});
    end
    apb(1'b1, 8'h03, 32'hB6);
    apb(1'b1, 8'h03, 32'h01);
    apb(1'b0, 8'h03, 32'h0);
    chk("nvm busy", 32'h1, {24'h0, rd[7:0]});
    chk("duty", 32'h0, {23'h0, duty});
    repeat (25) @(posedge pclk);
    apb(1'b0, 8'h03, 32'h0);
    chk("nvm done", 32'h0, {24'h0, rd[7:0]});
    // Spoil the live copy, then cycle the supply: the reload must undo it.
    for (int k = 0; k < 12; k++) begin
      apb(1'b1, 8'h20 + 8'(k), {24'h0, ~prm[k]});
    end
    fall <= 1'b0;
    rise <= 1'b0;
    repeat (2) @(posedge pclk);
    fall <= 1'b1;
    rise <= 1'b1;
    repeat (2) @(posedge pclk);
    for (int k = 0; k < 12; k++) begin
      apb(1'b0, 8'h20 + 8'(k), 32'h0);
      chk("param", {24'h0, prm[k]}, {24'h0, rd[7:0]});
    end
    apb(1'b0, 8'hFF, 32'h0);
    chk("pslverr", 32'h0, {31'h0, er});
    paddr <= 32'h400;
    end_of_test();
  end
endmodule
`default_nettype wire
